// ==== rtl/clock_fail_monitor.sv ====
// fail-safe clock monitor with an AHB-Lite register slave
// assumes hclk-free single clock clk, primary/secondary clock level
// sampled as a synchronous input, io pins passed through
// assumes whole-word bus transfers; other sizes are ignored
// assumes clk also stands for the internal RC that paces sampling
//
// Overview of operation
// - monitor active only with enable fuse
// - failure raises flag, switches to internal RC
// - fail-safe ends on reset, sleep, control write
// - sample clock is internal RC divided by 64
// - sample rising edge clears monitoring latch
// - system clock falling edge sets latch
// - sample falling edge with clear latch fails
// - crystal reset runs internal RC 1024 cycles
// - monitor enable also enables two-speed start; here start-up runs on internal RC without the fuse too
// - external or RC primary resumes immediately
// - after exit keep monitoring, secondary fail switches
// - interrupt only when fail interrupt enabled
// - failure forces select to 10, resets watchdog
// - non-crystal modes monitor right after start
// - crystal modes run internal RC until startup
// - no failure detected during startup timer
// - software clock switch releases watchdog counter
// - sleep clears watchdog, powerdown, sets timeout
// - pins hold drive state during sleep
// - select codes primary, timer1, internal, reserved
//
// The implementer's own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ns
module clock_fail_monitor #(
    parameter int unsigned SAMPLE_DIVIDE = clock_fail_monitor_pkg::SAMPLE_DIV,
    parameter int unsigned OST_COUNT = clock_fail_monitor_pkg::OST_CYCLES,
    parameter int unsigned IO_WIDTH = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire clock_fail_monitor_pkg::fuse_cfg_t fuse_cfg,
    input wire logic system_clock_in,
    input wire logic primary_osc_tick,
    input wire logic [IO_WIDTH-1:0] io_out_in,
    input wire logic [IO_WIDTH-1:0] io_oe_in,
    output logic [IO_WIDTH-1:0] io_out,
    output logic [IO_WIDTH-1:0] io_oe,
    output clock_fail_monitor_pkg::clock_out_t clock_out
);
    localparam int unsigned HALF_DIV = SAMPLE_DIVIDE / 2;
    localparam int unsigned DIV_W = $clog2(SAMPLE_DIVIDE);
    localparam int unsigned OST_W = $clog2(OST_COUNT + 1);
    localparam logic [2:0] WORD_SIZE = 3'h2;

    // one-hot; start-up doubles as the two-speed start phase
    typedef enum logic [3:0] {
        ST_STARTUP = 4'h1,
        ST_RUN = 4'h2,
        ST_FAILSAFE = 4'h4,
        ST_SLEEP = 4'h8
    } mon_state_t;

    function automatic logic is_crystal(
        input clock_fail_monitor_pkg::primary_osc_config_t m);
        is_crystal = (m == clock_fail_monitor_pkg::MODE_LP_CRYSTAL) ||
                     (m == clock_fail_monitor_pkg::MODE_XT_CRYSTAL) ||
                     (m == clock_fail_monitor_pkg::MODE_HS_CRYSTAL);
    endfunction

    // reserved select code is refused so the output never shows it
    function automatic logic sel_legal(input logic [1:0] s);
        sel_legal = (s == clock_fail_monitor_pkg::SCS_PRIMARY) ||
                    (s == clock_fail_monitor_pkg::SCS_TIMER1) ||
                    (s == clock_fail_monitor_pkg::SCS_INTERNAL);
    endfunction

    // byte and halfword transfers never reach the registers
    function automatic logic word_access(input logic sel,
        input logic [1:0] trans, input logic [2:0] size);
        word_access = sel && trans[1] && (size == WORD_SIZE);
    endfunction

    mon_state_t state_q;
    logic [DIV_W-1:0] div_q;
    logic sample_rise;
    logic sample_fall;

    logic sys_clk_prev_q;
    logic monitoring_latch_q;
    logic latch_meta_q;
    logic latch_sync_q;

    logic [OST_W-1:0] ost_q;
    logic startup_done_q;
    logic [1:0] scs_q;
    logic [2:0] internal_freq_select_q;
    logic osc_fail_flag_q;
    logic osc_fail_int_enable_q;
    logic powerdown_flag_q;
    logic timeout_flag_q;

    logic fail_detect;
    logic monitor_on;

    logic ap_valid_q;
    logic ap_write_q;
    logic [11:0] ap_addr_q;
    logic ctrl_write;
    logic cmd_write;
    logic sleep_cmd;
    logic wake_cmd;
    logic clr_flag_cmd;

    logic [31:0] rdata_d;

    // sample clock derived from the internal RC: clk stands for it here
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= '0;
        end else if (div_q == DIV_W'(SAMPLE_DIVIDE - 1)) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end
    assign sample_rise = (div_q == DIV_W'(SAMPLE_DIVIDE - 1));
    assign sample_fall = (div_q == DIV_W'(HALF_DIV - 1));

    // last level of the monitored clock, for its falling edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sys_clk_prev_q <= 1'b0;
        end else begin
            sys_clk_prev_q <= system_clock_in;
        end
    end

    // set wins: a system clock edge beside the clear still counts
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            monitoring_latch_q <= 1'b0;
        end else if (sys_clk_prev_q && !system_clock_in) begin
            monitoring_latch_q <= 1'b1;
        end else if (sample_rise) begin
            monitoring_latch_q <= 1'b0;
        end
    end

    // two flops into the sample domain; only the second is read
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            latch_meta_q <= 1'b0;
            latch_sync_q <= 1'b0;
        end else begin
            latch_meta_q <= monitoring_latch_q;
            latch_sync_q <= latch_meta_q;
        end
    end

    // two-speed start runs regardless of the fuse; detection idle in startup
    assign monitor_on = fuse_cfg.monitor_enable_fuse &&
                        (state_q == ST_RUN);
    // sync delay of two is far shorter than the half sample period
    assign fail_detect = monitor_on && sample_fall && !latch_sync_q;

    // bus address phase capture
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ap_valid_q <= 1'b0;
            ap_write_q <= 1'b0;
            ap_addr_q <= '0;
        end else if (hready) begin
            ap_valid_q <= word_access(hsel, htrans, hsize);
            ap_write_q <= hwrite;
            ap_addr_q <= haddr[11:0];
        end
    end
    assign ctrl_write = ap_valid_q && ap_write_q &&
                        (ap_addr_q == clock_fail_monitor_pkg::OSC_CONTROL_ADDR);
    assign cmd_write = ap_valid_q && ap_write_q &&
                       (ap_addr_q == clock_fail_monitor_pkg::COMMAND_ADDR);
    assign sleep_cmd = cmd_write &&
                       hwdata[clock_fail_monitor_pkg::CMD_SLEEP_BIT];
    assign wake_cmd = cmd_write &&
                      hwdata[clock_fail_monitor_pkg::CMD_WAKE_BIT];
    assign clr_flag_cmd = cmd_write &&
                          hwdata[clock_fail_monitor_pkg::CMD_CLR_FLAG_BIT];

    // any control write leaves fail-safe, even an unchanged select
    // main monitor sequence
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_STARTUP;
        end else begin
            unique case (state_q)
                ST_STARTUP: begin
                    if (sleep_cmd) begin
                        state_q <= ST_SLEEP;
                    end else if (startup_done_q) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (sleep_cmd) begin
                        state_q <= ST_SLEEP;
                    end else if (fail_detect) begin
                        state_q <= ST_FAILSAFE;
                    end
                end
                ST_FAILSAFE: begin
                    if (sleep_cmd) begin
                        state_q <= ST_SLEEP;
                    end else if (ctrl_write) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_SLEEP: begin
                    if (wake_cmd) begin
                        state_q <= ST_STARTUP;
                    end
                end
                default: state_q <= ST_STARTUP;
            endcase
        end
    end

    // a crystal that never starts keeps this waiting; software polls
    // start-up timer counts primary oscillator cycles for crystals only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ost_q <= '0;
            startup_done_q <= 1'b0;
        end else if (state_q == ST_SLEEP) begin
            ost_q <= '0;
            startup_done_q <= 1'b0;
        end else if (state_q == ST_STARTUP) begin
            if (!is_crystal(fuse_cfg.primary_osc_config)) begin
                startup_done_q <= 1'b1;
            end else if (ost_q == OST_W'(OST_COUNT)) begin
                startup_done_q <= 1'b1;
            end else if (primary_osc_tick) begin
                ost_q <= ost_q + 1'b1;
            end
        end
    end

    // control register: select, frequency, fail interrupt enable
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scs_q <= clock_fail_monitor_pkg::SCS_PRIMARY;
            internal_freq_select_q <= clock_fail_monitor_pkg::INTERNAL_FREQ_SELECT_RESET;
            osc_fail_int_enable_q <= 1'b0;
        end else if (fail_detect) begin
            scs_q <= clock_fail_monitor_pkg::SCS_INTERNAL;
        end else if (ctrl_write) begin
            // reserved code refused; the write still ends fail-safe
            if (sel_legal(hwdata[clock_fail_monitor_pkg::SCS_LSB +: 2])) begin
                scs_q <= hwdata[clock_fail_monitor_pkg::SCS_LSB +: 2];
            end
            internal_freq_select_q <= hwdata[clock_fail_monitor_pkg::INTERNAL_FREQ_SELECT_LSB +: 3];
            osc_fail_int_enable_q <=
                hwdata[clock_fail_monitor_pkg::OSC_FAIL_INT_ENABLE_BIT + 8];
        end
    end

    // failure flag: detection wins over a simultaneous clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            osc_fail_flag_q <= 1'b0;
        end else if (fail_detect) begin
            osc_fail_flag_q <= 1'b1;
        end else if (clr_flag_cmd) begin
            osc_fail_flag_q <= 1'b0;
        end
    end

    // power status bits; reset leaves them as after power-on
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            powerdown_flag_q <= 1'b1;
            timeout_flag_q <= 1'b1;
        end else if (sleep_cmd) begin
            powerdown_flag_q <= 1'b0;
            timeout_flag_q <= 1'b1;
        end
    end

    // clock, watchdog and interrupt outputs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clock_out <= '{clock_sel: clock_fail_monitor_pkg::SCS_INTERNAL,
                           osc_driver_on: 1'b1, watchdog_clear: 1'b0,
                           watchdog_release: 1'b0, int_request: 1'b0};
        end else begin
            if (state_q == ST_FAILSAFE || state_q == ST_STARTUP) begin
                clock_out.clock_sel <=
                    clock_fail_monitor_pkg::SCS_INTERNAL;
            end else begin
                clock_out.clock_sel <= scs_q;
            end
            clock_out.osc_driver_on <= (state_q != ST_SLEEP) && !sleep_cmd;
            // one pulse even when a failure runs straight into sleep
            clock_out.watchdog_clear <= fuse_cfg.watchdog_enable &&
                (fail_detect || sleep_cmd) &&
                !clock_out.watchdog_clear;
            if (ctrl_write && fuse_cfg.watchdog_enable) begin
                clock_out.watchdog_release <= 1'b1;
            end else if (state_q == ST_SLEEP) begin
                clock_out.watchdog_release <= 1'b0;
            end
            clock_out.int_request <= osc_fail_flag_q &&
                osc_fail_int_enable_q;
        end
    end

    // pins frozen in sleep
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            io_out <= '0;
            io_oe <= '0;
        end else if (state_q != ST_SLEEP) begin
            io_out <= io_out_in;
            io_oe <= io_oe_in;
        end
    end

    // read mux, decoded while the address phase stands
    always_comb begin
        rdata_d = 32'h00000000;
        unique case (haddr[11:0])
            clock_fail_monitor_pkg::OSC_CONTROL_ADDR: begin
                rdata_d[clock_fail_monitor_pkg::SCS_LSB +: 2] = scs_q;
                rdata_d[clock_fail_monitor_pkg::INTERNAL_FREQ_SELECT_LSB +: 3] = internal_freq_select_q;
                rdata_d[clock_fail_monitor_pkg::OSC_FAIL_INT_ENABLE_BIT + 8] =
                    osc_fail_int_enable_q;
            end
            clock_fail_monitor_pkg::STATUS_ADDR: begin
                rdata_d[clock_fail_monitor_pkg::OSC_FAIL_FLAG_BIT] = osc_fail_flag_q;
                rdata_d[clock_fail_monitor_pkg::STARTUP_DONE_STATUS_BIT] = startup_done_q;
                rdata_d[clock_fail_monitor_pkg::PD_BIT] = powerdown_flag_q;
                rdata_d[clock_fail_monitor_pkg::TO_BIT] = timeout_flag_q;
                rdata_d[clock_fail_monitor_pkg::FAILSAFE_BIT] =
                    (state_q == ST_FAILSAFE);
                rdata_d[clock_fail_monitor_pkg::SLEEP_BIT] =
                    (state_q == ST_SLEEP);
            end
            clock_fail_monitor_pkg::CONFIG_ADDR: begin
                rdata_d[0] = fuse_cfg.monitor_enable_fuse;
                rdata_d[1] = fuse_cfg.watchdog_enable;
                rdata_d[4:2] = fuse_cfg.primary_osc_config;
            end
            default: rdata_d = 32'h00000000;
        endcase
    end

    // zero wait states; read data registered at the address phase
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (hready && !hwrite &&
                     word_access(hsel, htrans, hsize)) begin
            hrdata <= rdata_d;
        end
    end
endmodule // clock_fail_monitor

// ==== pkg/clock_fail_monitor_pkg.sv ====
// constants and carriers shared by the fail-safe clock monitor
// assumes one 20 MHz clock and word-wide AHB-Lite register access
package clock_fail_monitor_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned SAMPLE_DIV = 64;
    localparam int unsigned OST_CYCLES = 1024;
    localparam int unsigned WDT_RIPPLE_BITS = 10;
    localparam logic [11:0] OSC_CONTROL_ADDR = 12'h000;
    localparam logic [11:0] STATUS_ADDR = 12'h004;
    localparam logic [11:0] CONFIG_ADDR = 12'h008;
    localparam logic [11:0] COMMAND_ADDR = 12'h00C;
    localparam int unsigned SCS_LSB = 0;
    localparam int unsigned INTERNAL_FREQ_SELECT_LSB = 4;
    localparam int unsigned OSC_FAIL_FLAG_BIT = 0;
    localparam int unsigned OSC_FAIL_INT_ENABLE_BIT = 1;
    localparam int unsigned STARTUP_DONE_STATUS_BIT = 2;
    localparam int unsigned FAILSAFE_BIT = 5;
    localparam int unsigned PD_BIT = 3;
    localparam int unsigned TO_BIT = 4;
    localparam int unsigned SLEEP_BIT = 6;
    localparam int unsigned CMD_SLEEP_BIT = 0;
    localparam int unsigned CMD_WAKE_BIT = 1;
    localparam int unsigned CMD_CLR_FLAG_BIT = 2;
    localparam logic [1:0] SCS_PRIMARY = 2'h0;
    localparam logic [1:0] SCS_TIMER1 = 2'h1;
    localparam logic [1:0] SCS_INTERNAL = 2'h2;
    localparam logic [2:0] INTERNAL_FREQ_SELECT_RESET = 3'h0;
    typedef enum logic [2:0] {
        MODE_EXT_CLOCK = 3'h0,
        MODE_RC = 3'h1,
        MODE_INTERNAL_RC = 3'h2,
        MODE_LP_CRYSTAL = 3'h3,
        MODE_XT_CRYSTAL = 3'h4,
        MODE_HS_CRYSTAL = 3'h5
    } primary_osc_config_t;
    typedef struct packed {
        logic monitor_enable_fuse;
        logic watchdog_enable;
        primary_osc_config_t primary_osc_config;
    } fuse_cfg_t;
    typedef struct packed {
        logic [1:0] clock_sel;
        logic osc_driver_on;
        logic watchdog_clear;
        logic watchdog_release;
        logic int_request;
    } clock_out_t;
endpackage

// ==== verification/primary_osc_model.sv ====
// primary oscillator model: monitored clock plus one tick per cycle
// assumes the bench clock; run low stalls the clock at its level
`timescale 1ns/1ns
module primary_osc_model (
    input wire logic clk,
    input wire logic run,
    input wire logic [3:0] half,
    output logic osc_clk,
    output logic osc_tick
);
    logic [3:0] cnt_q = 4'h0;
    initial osc_clk = 1'b0;
    initial osc_tick = 1'b0;
    // a dead crystal stops where it is, it does not idle high
    always @(posedge clk) begin
        osc_tick <= 1'b0;
        if (run && cnt_q >= half) begin
            cnt_q <= 4'h0;
            osc_clk <= !osc_clk;
            osc_tick <= !osc_clk;
        end else if (run) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule // primary_osc_model

// ==== verification/clock_fail_monitor_assertions.sv ====
// port checker for the fail-safe clock monitor
// assumes one clock domain; bound to clock_fail_monitor
`timescale 1ns/1ns
module clock_fail_monitor_assertions #(
    parameter int unsigned IO_WIDTH = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire clock_fail_monitor_pkg::fuse_cfg_t fuse_cfg,
    input wire logic system_clock_in,
    input wire logic [IO_WIDTH-1:0] io_out_in,
    input wire logic [IO_WIDTH-1:0] io_oe_in,
    input wire logic [IO_WIDTH-1:0] io_out,
    input wire logic [IO_WIDTH-1:0] io_oe,
    input wire clock_fail_monitor_pkg::clock_out_t clock_out
);
    logic take_q;
    logic ie_q;
    logic sck_q;
    logic [7:0] idle_q;
    wire wr_take = hsel && htrans[1] && hwrite && hready;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // any write may restart monitoring, so it restarts the count
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            take_q <= 1'b0;
            ie_q <= 1'b0;
            sck_q <= 1'b0;
            idle_q <= 8'h00;
        end else begin
            take_q <= wr_take && haddr[11:0] == 12'h000;
            if (take_q) begin
                ie_q <= hwdata[9];
            end
            sck_q <= system_clock_in;
            if (sck_q != system_clock_in || wr_take
                    || !clock_out.osc_driver_on) begin
                idle_q <= 8'h00;
            end else if (idle_q != 8'hFF) begin
                idle_q <= idle_q + 8'h01;
            end
        end
    end
    sequence s_asleep;
        !clock_out.osc_driver_on [*3];
    endsequence
    sequence s_awake;
        clock_out.osc_driver_on [*3];
    endsequence
    AST_NO_FUSE: assert property (
        !fuse_cfg.monitor_enable_fuse |-> !clock_out.int_request)
        else $error("interrupt with monitor fuse off");
    AST_FAIL_SWITCH: assert property (
        fuse_cfg.monitor_enable_fuse && idle_q == 8'hC8 |->
        clock_out.clock_sel == clock_fail_monitor_pkg::SCS_INTERNAL)
        else $error("stalled clock not replaced");
    AST_INT_EN: assert property (
        clock_out.int_request |-> ie_q || $past(ie_q))
        else $error("interrupt while disabled");
    AST_WDT_PULSE: assert property (
        clock_out.watchdog_clear |=> !clock_out.watchdog_clear)
        else $error("watchdog clear longer than a cycle");
    AST_SLEEP_WDT: assert property (
        fuse_cfg.watchdog_enable && $fell(clock_out.osc_driver_on) |->
        $past(clock_out.watchdog_clear) or ##[0:1] clock_out.watchdog_clear)
        else $error("sleep without watchdog clear");
    AST_SLEEP_IO: assert property (
        s_asleep |-> $stable(io_out) && $stable(io_oe))
        else $error("pins moved in sleep");
    AST_IO_PASS: assert property (
        s_awake |-> io_out == $past(io_out_in) && io_oe == $past(io_oe_in))
        else $error("pins not following core");
    AST_SEL_CODE: assert property (
        clock_out.clock_sel != 2'h3)
        else $error("reserved select code");
endmodule // clock_fail_monitor_assertions
bind clock_fail_monitor clock_fail_monitor_assertions #(
    .IO_WIDTH(IO_WIDTH)
) clock_fail_monitor_assertions_inst (
    .clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .fuse_cfg, .system_clock_in, .io_out_in, .io_oe_in, .io_out, .io_oe,
    .clock_out
);

// ==== verification/clock_fail_monitor_tb_top.sv ====
// bench for the fail-safe clock monitor, random ctrl and pin data
// assumes the oscillator model and the bound port checker
`timescale 1ns/1ns
`define CHK(g, e) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
    end \
end
module clock_fail_monitor_tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic run = 1'b0;
    logic wdc_seen = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [3:0] half = 4'h3;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rdat, io_keep;
    logic [15:0] io_out_in = 16'h0;
    logic [15:0] io_oe_in = 16'h0;
    logic [15:0] lfsr_q = 16'h002D;
    logic [15:0] io_out, io_oe;
    logic hreadyout, hresp, sck, tick;
    clock_fail_monitor_pkg::fuse_cfg_t fuse_cfg = '0;
    clock_fail_monitor_pkg::clock_out_t clock_out;
    wire hready = hreadyout;
    int failures = 0;
    int n_compared = 0;
    int cyc;
    clock_fail_monitor #(.OST_COUNT(8)) clock_fail_monitor_inst (
        .clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .fuse_cfg,
        .system_clock_in(sck), .primary_osc_tick(tick), .io_out_in,
        .io_oe_in, .io_out, .io_oe, .clock_out);
    primary_osc_model primary_osc_model_inst (.clk, .run, .half,
        .osc_clk(sck), .osc_tick(tick));
    initial forever #25 clk = !clk;
    always @(posedge clk) begin
        if (clock_out.watchdog_clear === 1'b1) begin
            wdc_seen <= 1'b1;
        end
    end
    task automatic test_done();
        if (failures == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    function automatic logic [15:0] step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [31:0] ctrl_val(input logic [1:0] s,
        input logic [2:0] f, input logic ie);
        return {22'h0, ie, 2'h0, f, 2'h0, s};
    endfunction
    // 0 interrupt, 1 asleep, 2 awake, 3+n select code n
    function automatic logic hit(input int k);
        case (k)
            0: return clock_out.int_request === 1'b1;
            1: return clock_out.osc_driver_on === 1'b0;
            2: return clock_out.osc_driver_on === 1'b1;
            default: return clock_out.clock_sel === 2'(k - 3);
        endcase
    endfunction
    task automatic wait_on(input int k, input int lim);
        cyc = 0;
        while (!hit(k)) begin
            @(posedge clk);
            cyc++;
            if (cyc > lim) begin
                failures++;
                test_done();
            end
        end
    endtask
    // each phase ends at the first edge that samples hready high
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n > 20) begin
                failures++;
                test_done();
            end
        end while (hready !== 1'b1);
    endtask
    task automatic bus(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, a};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rdat = hrdata;
        `CHK(hresp, 1'b0)
    endtask
    task automatic rd_status();
        bus(1'b0, clock_fail_monitor_pkg::STATUS_ADDR, 32'h0);
    endtask
    task automatic wr_ctrl(input logic [31:0] d);
        bus(1'b1, clock_fail_monitor_pkg::OSC_CONTROL_ADDR, d);
    endtask
    task automatic wr_cmd(input logic [31:0] d);
        bus(1'b1, clock_fail_monitor_pkg::COMMAND_ADDR, d);
    endtask
    task automatic do_reset(input logic en,
        input clock_fail_monitor_pkg::primary_osc_config_t m);
        reset_n <= 1'b0;
        fuse_cfg <= '{en, 1'b1, m};
        repeat (10) @(posedge clk);
        `CHK(clock_out.clock_sel, 2'h2)
        reset_n <= 1'b1;
    endtask
    initial begin
        @(posedge clk);
        do_reset(1'b1, clock_fail_monitor_pkg::MODE_XT_CRYSTAL);
        run <= 1'b1;
        wait_on(3, 400);
        `CHK(cyc >= 50, 1'b1)
        rd_status();
        `CHK(rdat[2], 1'b1)
        bus(1'b0, 12'h010, 32'h0);
        `CHK(rdat, 32'h00000000)
        for (int i = 0; i < 6; i++) begin
            lfsr_q = step(lfsr_q);
            io_out_in <= lfsr_q;
            io_oe_in <= ~lfsr_q;
            wr_ctrl(ctrl_val(2'(i % 3), lfsr_q[6:4], 1'b0));
            bus(1'b0, clock_fail_monitor_pkg::OSC_CONTROL_ADDR, 32'h0);
            `CHK(rdat & 32'h00000273, ctrl_val(2'(i % 3), lfsr_q[6:4], 1'b0))
            `CHK(clock_out.clock_sel, 2'(i % 3))
            `CHK(clock_out.watchdog_release, 1'b1)
        end
        wr_ctrl(ctrl_val(2'h0, 3'h0, 1'b1));
        run <= 1'b0;
        repeat (3) @(posedge clk);
        wdc_seen = 1'b0;
        wait_on(0, 300);
        rd_status();
        `CHK({rdat[5], rdat[0]}, 2'h3)
        `CHK(clock_out.clock_sel, clock_fail_monitor_pkg::SCS_INTERNAL)
        `CHK(wdc_seen, 1'b1)
        // restart first so a stale latch cannot fail again at once
        run <= 1'b1;
        repeat (70) @(posedge clk);
        wr_cmd(32'h00000004);
        wr_ctrl(ctrl_val(2'h1, 3'h0, 1'b1));
        rd_status();
        `CHK({rdat[5], rdat[0]}, 2'h0)
        `CHK(clock_out.clock_sel, 2'h1)
        run <= 1'b0;
        wait_on(5, 300);
        wr_ctrl(ctrl_val(2'h2, 3'h0, 1'b0));
        rd_status();
        `CHK(rdat[0], 1'b1)
        `CHK(clock_out.int_request, 1'b0)
        run <= 1'b1;
        repeat (70) @(posedge clk);
        wr_ctrl(ctrl_val(2'h0, 3'h0, 1'b0));
        run <= 1'b0;
        wait_on(5, 300);
        wdc_seen = 1'b0;
        wr_cmd(32'h00000001);
        wait_on(1, 20);
        repeat (2) @(posedge clk);
        io_keep = {io_out, io_oe};
        lfsr_q = step(lfsr_q);
        io_out_in <= lfsr_q;
        io_oe_in <= ~io_oe_in;
        repeat (5) @(posedge clk);
        `CHK({io_out, io_oe}, io_keep)
        rd_status();
        `CHK(rdat[6:3], 4'hA)
        `CHK(wdc_seen, 1'b1)
        wr_cmd(32'h00000002);
        wait_on(2, 20);
        repeat (300) @(posedge clk);
        rd_status();
        `CHK({rdat[5], rdat[2]}, 2'h0)
        do_reset(1'b1, clock_fail_monitor_pkg::MODE_EXT_CLOCK);
        wait_on(3, 20);
        `CHK(cyc, 4)
        wait_on(5, 300);
        do_reset(1'b0, clock_fail_monitor_pkg::MODE_RC);
        wait_on(3, 20);
        `CHK(cyc, 4)
        repeat (300) @(posedge clk);
        rd_status();
        `CHK({clock_out.clock_sel, rdat[0]}, 3'h0)
        test_done();
    end
endmodule // clock_fail_monitor_tb_top
